// *** include/spi_port_map.vh ***
// constants for the paged serial register port: offsets, field positions,
// reset values and frame counts; included by bare name from src/
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH

// register offsets
`define CFG_ADDR 8'h00
`define CFG2_ADDR 8'h01
`define BCAST_ADDR 8'hFF

// serial_port_config fields, each mirrored in two bits
`define CFG_LSB_HI 6
`define CFG_LSB_LO 1
`define CFG_ASC_HI 5
`define CFG_ASC_LO 2
`define CFG_4W_HI 4
`define CFG_4W_LO 3
`define CFG_RESET 8'h00

// broadcast control field
`define BCAST_BIT 1
`define BCAST_RESET 8'h00

// instruction word layout
`define INSTR_BITS 16
`define INSTR_LAST 4'hF
`define IW_RW 15
`define IW_A14 14
`define IW_A13 13
`define IW_PAGE_HI 12
`define IW_PAGE_LO 9
`define IW_A8 8
`define BYTE_LAST 3'h7

// synchroniser reset: straps and data low, select high, clock low
`define PIN_SYNC_RESET 8'h02

`endif

// *** sim/paged_spi_register_port_monitor.sv ***
// checker for the paged serial register port, watching top-level pins only
// assumes one clock, mclk_in, and a synchronous active-low reset
`timescale 1ns/10ps
module paged_spi_register_port_monitor (
	// clock and reset
	input wire mclk_in,
	input wire rst_b_in,
	// serial pins
	input wire cs_b_in,
	input wire sdio_oe_out,
	input wire serial_data_out_oe_out,
	// write stream and status
	input wire wr_valid_out,
	input wire wr_ready_in,
	input wire [7:0] wr_addr_out,
	input wire [7:0] wr_data_out,
	input wire four_wire_select_out,
	input wire broadcast_write_enable_out,
	input wire wr_overrun_out
);
	// ----------------
	// checks
	// ----------------
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	// four idle cycles cover the pin synchroniser delay
	chk_idle_float: assert property (cs_b_in [*4] |-> !sdio_oe_out && !serial_data_out_oe_out)
		else $error("data pin driven while deselected");
	chk_one_driver: assert property (!(sdio_oe_out && serial_data_out_oe_out))
		else $error("both data outputs driven");
	chk_sdio_mode: assert property (sdio_oe_out |-> !four_wire_select_out)
		else $error("shared pin driven in four-wire mode");
	chk_sdo_mode: assert property (serial_data_out_oe_out |-> four_wire_select_out)
		else $error("separate output driven in three-wire mode");
	chk_head_hold: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable({wr_addr_out, wr_data_out}))
		else $error("buffered write changed before pop");
	chk_reset_clear: assert property (disable iff (1'b0) !rst_b_in |=> !broadcast_write_enable_out && !four_wire_select_out && !wr_valid_out)
		else $error("control not cleared by reset");
	chk_ctrl_idle: assert property (cs_b_in [*8] |-> $stable(four_wire_select_out) && $stable(broadcast_write_enable_out))
		else $error("control changed outside a frame");
	chk_no_push_idle: assert property (cs_b_in [*8] |-> !$rose(wr_valid_out))
		else $error("write pushed outside a frame");
	chk_overrun_sticky: assert property (wr_overrun_out |=> wr_overrun_out)
		else $error("overrun flag cleared without reset");
endmodule

bind paged_spi_register_port paged_spi_register_port_monitor mon (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
	.cs_b_in(cs_b_in), .sdio_oe_out(sdio_oe_out), .serial_data_out_oe_out(serial_data_out_oe_out),
	.wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in), .wr_addr_out(wr_addr_out),
	.wr_data_out(wr_data_out), .four_wire_select_out(four_wire_select_out),
	.broadcast_write_enable_out(broadcast_write_enable_out), .wr_overrun_out(wr_overrun_out));

// *** sim/spi_host_model.sv ***
// host serial controller model: frames, instruction and byte stream
// assumes frame() is called 1 ns after an mclk edge, one frame at a time
`timescale 1ns/10ps
module spi_host_model (
	// clock
	input wire mclk_in,
	// device pins
	input wire sdio_out,
	input wire sdio_oe_out,
	input wire serial_data_out_out,
	input wire serial_data_out_oe_out,
	output logic sclk = 0,
	output logic cs_b = 1,
	output logic sdio
);
	logic drv = 0, dv = 0, last = 0, so, so_last = 0;
	bit seen;
	logic [7:0] sh, wq[$], rq[$];
	// no pull on either line, so a released line shows the inverse of its last level
	always @* sdio = sdio_oe_out ? sdio_out : (drv ? dv : !last);
	always @* so = serial_data_out_oe_out ? serial_data_out_out : !so_last;
	always @(posedge mclk_in) begin
		last <= sdio;
		so_last <= so;
	end
	// ----------------
	// one frame; sclk period is 8 mclk (200 ns)
	// ----------------
	task frame(input bit rd, input logic [14:0] a, input int nb, input bit lsb, input bit fw);
		int i, k;
		seen = 0;
		@(posedge mclk_in) #1 cs_b = 0;
		for (i = 0; i < nb; i++) begin
			k = i < 16 ? (lsb ? i : 15 - i) : (lsb ? i % 8 : 7 - i % 8);
			if (i >= 16 && i % 8 == 0 && !rd) sh = wq.pop_front();
			drv = !(rd && i >= 16);
			dv = i < 16 ? (k == 15 ? rd : a[k]) : sh[k]; // change data after the falling edge
			repeat (4) @(posedge mclk_in);
			#1 sclk = 1;
			// read bits are taken at the rising edge
			if (rd && i >= 16) begin
				sh[k] = fw ? so : sdio;
				seen = seen | (fw ? serial_data_out_oe_out : sdio_oe_out);
				if (i % 8 == 7) rq.push_back(sh);
			end
			repeat (4) @(posedge mclk_in);
			#1 sclk = 0;
		end
		drv = 0;
		repeat (4) @(posedge mclk_in);
		#1 cs_b = 1; // end the stream after the last byte
		repeat (8) @(posedge mclk_in);
		#1;
	endtask
endmodule

// *** sim/test_paged_spi_register_port.sv ***
// self-checking bench for the paged serial register port
// assumes the host model in spi_host_model.sv and straps set to page 5
`timescale 1ns/10ps
module test_paged_spi_register_port;
	logic mclk_in = 0, rst_b_in = 0, wr_ready_in = 1;
	logic [3:0] strap = 4'h5;
	wire sclk, cs_b, sdio, sd_o, sd_oe, so, so_oe, wv, fw, bc, ovr;
	wire [7:0] wa, wd;
	int miscompares = 0, checks = 0, cyc = 0;
	logic [15:0] pq[$];
	always #12.5 mclk_in = !mclk_in;
	paged_spi_register_port uut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .sclk_in(sclk), .cs_b_in(cs_b),
		.sdio_in(sdio), .sdio_out(sd_o), .sdio_oe_out(sd_oe), .serial_data_out_out(so),
		.serial_data_out_oe_out(so_oe), .page_strap_3_in(strap[3]), .page_strap_2_in(strap[2]),
		.page_strap_1_in(strap[1]), .page_strap_0_in(strap[0]), .wr_valid_out(wv), .wr_addr_out(wa),
		.wr_data_out(wd), .wr_ready_in(wr_ready_in), .four_wire_select_out(fw),
		.broadcast_write_enable_out(bc), .wr_overrun_out(ovr));
	spi_host_model host (.mclk_in(mclk_in), .sdio_out(sd_o), .sdio_oe_out(sd_oe), .serial_data_out_out(so),
		.serial_data_out_oe_out(so_oe), .sclk(sclk), .cs_b(cs_b), .sdio(sdio));
	// collect popped writes; the cycle ceiling is far above the ~4000 cycles needed
	always @(posedge mclk_in) begin
		cyc++;
		if (wv === 1'b1 && wr_ready_in === 1'b1) pq.push_back({wa, wd});
		if (cyc == 30000) begin
			miscompares++;
			stop_test;
		end
	end
	// ----------------
	// tasks
	// ----------------
	task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [14:0] a, input logic [15:0] d, input int nb, input bit lsb);
		host.wq.push_back(d[15:8]);
		host.wq.push_back(d[7:0]);
		host.frame(0, a, nb, lsb, 0);
		host.wq.delete();
	endtask
	task rd(input logic [14:0] a, input logic [15:0] e, input bit lsb, input bit fw4, input bit dr);
		host.rq.delete();
		host.frame(1, a, 32, lsb, fw4);
		cmp("read_oe", dr, host.seen);
		if (dr) cmp("read_data", e, {host.rq[0], host.rq[1]});
	endtask
	task pk(input logic [15:0] e);
		cmp("push", e, pq.size() != 0 ? pq.pop_front() : 16'hXXXX);
	endtask
	task stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ----------------
	// sequence; address = {A14,A13,page,A8,index}, page 5 is 15'h0A00
	// ----------------
	initial begin
		repeat (2) @(posedge mclk_in);
		#1 rst_b_in = 1;
		repeat (3) @(posedge mclk_in);
		#1 cmp("status", 0, {fw, bc, ovr, wv});
		wr(15'h0A10, 16'hA53C, 32, 0);
		pk(16'h10A5);
		pk(16'h0F3C);
		rd(15'h0A10, 16'hA53C, 0, 0, 1);
		wr(15'h0C20, 16'h1111, 24, 0);
		wr(15'h4A20, 16'h1111, 24, 0);
		wr(15'h0A20, 16'h1111, 10, 0);
		wr(15'h0A20, 16'h77EE, 28, 0);
		pk(16'h2077);
		cmp("extra", 0, 16'(pq.size()));
		rd(15'h0C10, 0, 0, 0, 0);
		wr(15'h0000, 16'h3C00, 24, 0);
		pk(16'h003C);
		cmp("four_wire", 1, fw);
		rd(15'h0A0F, 16'h3CA5, 0, 1, 1);
		wr(15'h0AFF, 16'h0200, 24, 0);
		pk(16'hFF02);
		cmp("broadcast", 1, bc);
		rd(15'h0AFF, 16'h023C, 0, 1, 1);
		wr(15'h1230, 16'h5A00, 24, 0);
		pk(16'h305A);
		rd(15'h1230, 0, 0, 1, 0);
		wr(15'h0000, 16'h7E00, 24, 0);
		pk(16'h007E);
		wr(15'h0A40, 16'h1E35, 32, 1);
		pk(16'h401E);
		pk(16'h4135);
		rd(15'h0A40, 16'h1E35, 1, 1, 1);
		// stall the sink so the third byte finds the buffer full
		wr_ready_in = 0;
		host.wq.push_back(8'h99);
		wr(15'h0A50, 16'h1234, 40, 1);
		wr_ready_in = 1;
		repeat (4) @(posedge mclk_in);
		#1 pk(16'h5099);
		pk(16'h5112);
		cmp("overrun", 16'h0001, {pq.size() != 0, ovr});
		stop_test;
	end
endmodule

// *** src/paged_spi_register_port.v ***
// paged serial register port: instruction plus byte stream framed by an
// active-low chip select, with 3/4-wire, bit order and address stepping.
// assumes every serial pin is asynchronous to mclk_in and that the serial
// clock runs at most about a fifth of mclk_in so edges are seen after sync.
`timescale 1ns/10ps
`include "spi_port_map.vh"

module paged_spi_register_port (
	// clock and reset
	input wire mclk_in,
	input wire rst_b_in,
	// serial pins
	input wire sclk_in,
	input wire cs_b_in,
	input wire sdio_in,
	output reg sdio_out,
	output reg sdio_oe_out,
	output reg serial_data_out_out,
	output reg serial_data_out_oe_out,
	// page straps
	input wire page_strap_3_in,
	input wire page_strap_2_in,
	input wire page_strap_1_in,
	input wire page_strap_0_in,
	// write stream to the rest of the chip
	output reg wr_valid_out,
	output reg [7:0] wr_addr_out,
	output reg [7:0] wr_data_out,
	input wire wr_ready_in,
	// status
	output reg four_wire_select_out,
	output reg broadcast_write_enable_out,
	output reg wr_overrun_out
);

	// frame states
	localparam ST_IDLE = 2'b00;
	localparam ST_INSTR = 2'b01;
	localparam ST_DATA = 2'b10;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg [7:0] pin_s1;
	reg [7:0] pin_s2;
	reg sclk_d;
	reg cs_b_d;
	// second stage outputs, the only copies that logic may read
	wire sclk_s = pin_s2[0];
	wire cs_b_s = pin_s2[1];
	wire sdio_s = pin_s2[2];
	wire [3:0] strap_s = pin_s2[6:3];

	// first stage feeds only the second stage; reset loads the idle pin
	// levels (select high, clock low) so the edge detectors see no false
	// edge in the cycles after reset
	always @(posedge mclk_in) begin
		if (!rst_b_in) begin
			pin_s1 <= `PIN_SYNC_RESET;
			pin_s2 <= `PIN_SYNC_RESET;
			sclk_d <= 1'b0;
			cs_b_d <= 1'b1;
		end else begin
			pin_s1 <= {1'b0, page_strap_3_in, page_strap_2_in, page_strap_1_in, page_strap_0_in,
				sdio_in, cs_b_in, sclk_in};
			pin_s2 <= pin_s1;
			sclk_d <= sclk_s;
			cs_b_d <= cs_b_s;
		end
	end

	// edges qualified by a low select so clock activity between frames
	// shifts nothing; detection costs three mclk of latency
	wire sclk_rise = sclk_s & ~sclk_d & ~cs_b_s;
	wire sclk_fall = ~sclk_s & sclk_d & ~cs_b_s;
	wire cs_fall = ~cs_b_s & cs_b_d;

	// ----------------------------------------------------------------
	// registers and image
	// ----------------------------------------------------------------
	// control registers live in flops; everything else is a plain byte
	// image that reads back what was written, reserved locations included
	reg [7:0] serial_port_config;
	reg [7:0] bcast_reg;
	reg [7:0] reg_image [0:255];

	// each field is mirrored in two bits so a host that guesses the wrong
	// bit order on its first write still sets the field it meant
	wire cfg_lsb = serial_port_config[`CFG_LSB_HI] | serial_port_config[`CFG_LSB_LO];
	wire cfg_asc = serial_port_config[`CFG_ASC_HI] | serial_port_config[`CFG_ASC_LO];
	wire cfg_4w = serial_port_config[`CFG_4W_HI] | serial_port_config[`CFG_4W_LO];
	wire bcast_en = bcast_reg[`BCAST_BIT];

	// ----------------------------------------------------------------
	// frame state
	// ----------------------------------------------------------------
	// per-frame context; bit order and stepping are frozen at select fall and
	// permissions once the instruction is complete so a write to config cannot upset the
	// frame that carries it
	reg [1:0] state;
	reg [3:0] icnt;
	reg [2:0] bcnt;
	reg [15:0] instr;
	reg is_read;
	reg wr_ok;
	reg rd_ok;
	reg lsb_mode;
	reg asc_mode;
	reg [7:0] ptr;
	reg [7:0] rx_shift;
	reg [7:0] tx_shift;
	reg load_pend;
	reg [7:0] rd_byte;

	// bit position depends on order latched for this frame
	wire [15:0] next_instr = lsb_mode ? {sdio_s, instr[15:1]} : {instr[14:0], sdio_s};
	wire [7:0] next_rx = lsb_mode ? {sdio_s, rx_shift[7:1]} : {rx_shift[6:0], sdio_s};
	wire [7:0] step_ptr = asc_mode ? ptr + 8'h01 : ptr - 8'h01;

	// address checks on the finished instruction word
	wire addr_zero = ~next_instr[`IW_A14] & ~next_instr[`IW_A13] & ~next_instr[`IW_A8];
	wire [3:0] page = next_instr[`IW_PAGE_HI:`IW_PAGE_LO];
	wire page_hit = (page == strap_s);
	wire low_regs = (page == 4'h0) && (next_instr[7:0] == `CFG_ADDR || next_instr[7:0] == `CFG2_ADDR);
	// broadcast only widens writes; reads still need the straps
	wire next_wr_ok = addr_zero & (page_hit | low_regs | bcast_en);
	wire next_rd_ok = addr_zero & page_hit;

	// a byte completes on its eighth captured rise
	wire byte_done = (state == ST_DATA) && sclk_rise && (bcnt == `BYTE_LAST);
	wire commit = byte_done && !is_read && wr_ok;

	// read value seen by the pointer
	always @* begin
		if (ptr == `CFG_ADDR)
			rd_byte = serial_port_config;
		else if (ptr == `BCAST_ADDR)
			rd_byte = bcast_reg;
		else
			rd_byte = reg_image[ptr];
	end

	// frame sequencer: chip select restarts it, any abort drops partial work
	// a short instruction never reaches ST_DATA, so it can commit nothing
	always @(posedge mclk_in) begin
		if (!rst_b_in) begin
			state <= ST_IDLE;
			icnt <= 4'h0;
			bcnt <= 3'h0;
			instr <= 16'h0000;
			is_read <= 1'b0;
			wr_ok <= 1'b0;
			rd_ok <= 1'b0;
			lsb_mode <= 1'b0;
			asc_mode <= 1'b0;
			ptr <= 8'h00;
			rx_shift <= 8'h00;
			load_pend <= 1'b0;
		end else if (cs_b_s) begin
			state <= ST_IDLE;
			load_pend <= 1'b0;
		end else begin
			load_pend <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (cs_fall) begin
						// mode taken here so a config write acts on the next frame
						state <= ST_INSTR;
						lsb_mode <= cfg_lsb;
						asc_mode <= cfg_asc;
						icnt <= 4'h0;
						bcnt <= 3'h0;
					end
				end
				ST_INSTR: begin
					if (sclk_rise) begin
						instr <= next_instr;
						icnt <= icnt + 4'h1;
						// last instruction bit: decode permissions on the finished word
						if (icnt == `INSTR_LAST) begin
							state <= ST_DATA;
							is_read <= next_instr[`IW_RW];
							wr_ok <= next_wr_ok;
							rd_ok <= next_rd_ok;
							ptr <= next_instr[7:0];
							load_pend <= next_instr[`IW_RW];
						end
					end
				end
				ST_DATA: begin
					if (sclk_rise) begin
						rx_shift <= next_rx;
						bcnt <= bcnt + 3'h1;
						// byte boundary: step for the next byte; a read also reloads
						if (bcnt == `BYTE_LAST) begin
							ptr <= step_ptr;
							load_pend <= is_read;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// control flops take the byte at the same edge as the image so a read
	// in the next frame already sees the new value
	always @(posedge mclk_in) begin
		if (!rst_b_in) begin
			serial_port_config <= `CFG_RESET;
			bcast_reg <= `BCAST_RESET;
		end else if (commit) begin
			if (ptr == `CFG_ADDR)
				serial_port_config <= next_rx;
			if (ptr == `BCAST_ADDR)
				bcast_reg <= next_rx;
		end
	end

	// image holds data only, so it needs no reset
	// a write frame never launches, so image write and read never collide
	always @(posedge mclk_in) begin
		if (commit)
			reg_image[ptr] <= next_rx;
	end

	// ----------------------------------------------------------------
	// read launch
	// ----------------------------------------------------------------
	wire rd_active = (state == ST_DATA) && is_read && rd_ok;

	// next bit and next shifter value for the falling edge; the order is
	// the one latched at select fall, the pin follows the live wire mode
	wire tx_bit = lsb_mode ? tx_shift[0] : tx_shift[7];
	wire [7:0] next_tx = lsb_mode ? {1'b0, tx_shift[7:1]} : {tx_shift[6:0], 1'b0};

	// new byte loaded right after the boundary; the falling edge is still
	// several mclk cycles away at the supported serial rates
	// a refused read keeps both enables low for the whole frame
	always @(posedge mclk_in) begin
		if (!rst_b_in) begin
			tx_shift <= 8'h00;
			sdio_out <= 1'b0;
			sdio_oe_out <= 1'b0;
			serial_data_out_out <= 1'b0;
			serial_data_out_oe_out <= 1'b0;
		end else if (cs_b_s || !rd_active) begin
			sdio_oe_out <= 1'b0;
			serial_data_out_oe_out <= 1'b0;
			if (load_pend)
				tx_shift <= rd_byte;
		end else if (load_pend) begin
			tx_shift <= rd_byte;
		end else if (sclk_fall) begin
			// launch on the falling edge; pin picked by wire mode
			tx_shift <= next_tx;
			sdio_out <= tx_bit;
			serial_data_out_out <= tx_bit;
			sdio_oe_out <= ~cfg_4w;
			serial_data_out_oe_out <= cfg_4w;
		end
	end

	// ----------------------------------------------------------------
	// two-entry write buffer
	// ----------------------------------------------------------------
	// the serial host cannot be stalled, so a push into a full buffer is
	// flagged as overrun; the register image itself never misses a byte
	reg [15:0] buf1;
	reg buf1_valid;
	wire pop = wr_valid_out & wr_ready_in;
	// entry pushed on a commit: index then byte
	wire [15:0] push_word = {ptr, next_rx};

	always @(posedge mclk_in) begin
		if (!rst_b_in) begin
			wr_valid_out <= 1'b0;
			wr_addr_out <= 8'h00;
			wr_data_out <= 8'h00;
			buf1 <= 16'h0000;
			buf1_valid <= 1'b0;
			wr_overrun_out <= 1'b0;
		end else begin
			if (pop) begin
				// head leaves: refill from the second entry or from a commit
				if (buf1_valid) begin
					{wr_addr_out, wr_data_out} <= buf1;
					buf1_valid <= commit;
					if (commit)
						buf1 <= push_word;
				end else if (commit) begin
					{wr_addr_out, wr_data_out} <= push_word;
				end else begin
					wr_valid_out <= 1'b0;
				end
			end else if (commit) begin
				// no pop: a commit takes the first free entry, else it is flagged
				if (!wr_valid_out) begin
					{wr_addr_out, wr_data_out} <= push_word;
					wr_valid_out <= 1'b1;
				end else if (!buf1_valid) begin
					buf1 <= push_word;
					buf1_valid <= 1'b1;
				end else begin
					wr_overrun_out <= 1'b1;
				end
			end
		end
	end

	// status mirrors, one cycle behind the control registers, so that a
	// checker on the pins can follow them without seeing inside the block
	always @(posedge mclk_in) begin
		if (!rst_b_in) begin
			four_wire_select_out <= 1'b0;
			broadcast_write_enable_out <= 1'b0;
		end else begin
			four_wire_select_out <= cfg_4w;
			broadcast_write_enable_out <= bcast_en;
		end
	end

endmodule
